// [verilog/mcc_chopper_defines.svh]
`ifndef MCC_CHOPPER_DEFINES_SVH
`define MCC_CHOPPER_DEFINES_SVH

// Register index as printed; the byte address is four times the index
`define MCC_CHOPCONF_INDEX       12'h06d
`define MCC_CHOPCONF_ADDR        12'h1b4
`define MCC_CHOPCONF_RESET       32'h10410150
`define MCC_CHOPCONF_WMASK       32'hfffddfff

`define MCC_BIT_SUPPLY_SHORT_OFF 31
`define MCC_BIT_GROUND_SHORT_OFF 30
`define MCC_BIT_DOUBLE_EDGE      29
`define MCC_BIT_INTERPOLATE      28
`define MCC_MICROSTEP_RESOLUTION_MSB             27
`define MCC_MICROSTEP_RESOLUTION_LSB             24
`define MCC_PASSIVE_FAST_DECAY_TIME_MSB             23
`define MCC_PASSIVE_FAST_DECAY_TIME_LSB             20
`define MCC_BIT_HIGH_VEL_CHM     19
`define MCC_BIT_HIGH_VEL_FS      18
`define MCC_TBL_MSB              16
`define MCC_TBL_LSB              15
`define MCC_BIT_CHM              14
`define MCC_BIT_FD3              11
`define MCC_SLOW_DECAY_OFF_TIME_MSB             3
`define MCC_SLOW_DECAY_OFF_TIME_LSB             0

`define MCC_MICROSTEP_RESOLUTION_FULL_STEP       4'h8
`define MCC_BLANK_CODE0          11'h010
`define MCC_BLANK_CODE1          11'h018
`define MCC_BLANK_CODE2          11'h024
`define MCC_BLANK_CODE3          11'h036
`define MCC_PFD_CLOCKS_PER_UNIT  11'h080
`define MCC_OFF_BASE_CLOCKS      11'h018
`define MCC_OFF_CLOCKS_PER_UNIT  11'h020
`define MCC_POS_45_DEG           8'h80

`endif

// [verilog/mcc_chopper_pkg.sv]
`default_nettype none
package mcc_chopper_pkg;

  typedef struct packed {
    logic       supplyShortProtectOff;
    logic       groundShortProtectOff;
    logic       doubleEdge;
    logic       interpolate;
    logic [3:0] microstepResolution;
    logic [3:0] passiveFastDecayTime;
    logic       highVelChopper;
    logic       highVelFullStep;
    logic       unused17;
    logic [1:0] comparatorBlankTime;
    logic       chopperMode;
    logic       unused13;
    logic       fastDecayCompDisable;
    logic       fastDecaySelect;
    logic [3:0] hysteresisEndOffset;
    logic [2:0] hysteresisStartTfd;
    logic [3:0] slowDecayOffTime;
  } mcc_chopconf_t;

  typedef struct packed {
    logic supplyShortProtectOn;
    logic groundShortProtectOn;
    logic driverEnable;
    logic chopperModeEff;
    logic fastDecaySelectEff;
    logic fullStepActive;
  } mcc_drive_ctl_t;

  typedef struct packed {
    logic bridgesOff;
    logic blanking;
    logic onPhase;
    logic slowDecay;
    logic passiveFastDecay;
  } mcc_bridge_state_t;

  typedef enum {
    MCC_IDLE,
    MCC_PFD,
    MCC_ON,
    MCC_SLOW
  } mcc_phase_t;

endpackage
`default_nettype wire

// [verilog/mcc_phase_timer.sv]
`default_nettype none
// Down-counting phase timer; busy while the loaded count runs out
module mcc_phase_timer #(
  parameter int WIDTH = 11
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  busy
);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load)
      cnt_nxt = count;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - WIDTH'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign busy = (cnt_r != '0);

endmodule
`default_nettype wire

// [verilog/mcc_motor_chopper_config.sv]
// Implementation choice: the APB interface to the registers.
`default_nettype none
`include "mcc_chopper_defines.svh"

module mcc_motor_chopper_config (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic                                pready,
  output logic [31:0]                         prdata,
  output logic                                pslverr,
  input  wire logic                           stepIn,
  input  wire logic                           dirIn,
  input  wire logic                           currentTrip,
  input  wire logic                           polarityChange,
  input  wire logic                           velocityHigh,
  output mcc_chopper_pkg::mcc_drive_ctl_t     driveCtl,
  output mcc_chopper_pkg::mcc_bridge_state_t  bridgeState,
  output logic [9:0]                          microstepPos
);

  localparam int TW = 11;

  mcc_chopper_pkg::mcc_chopconf_t cfg_r;
  mcc_chopper_pkg::mcc_chopconf_t cfg_nxt;
  logic [31:0]                    rdata_r;
  logic [31:0]                    rdata_nxt;
  logic                           err_r;
  logic                           err_nxt;
  logic                           addrHit;

  // Read data is captured in the setup cycle so the access phase needs no wait state
  assign addrHit = (paddr == `MCC_CHOPCONF_ADDR);

  always_comb
  begin
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (psel && !penable)
    begin
      rdata_nxt = addrHit ? (32'(cfg_r) & `MCC_CHOPCONF_WMASK) : 32'h00000000;
      err_nxt   = !addrHit;
    end
    if (psel && penable && pwrite && addrHit)
      cfg_nxt = mcc_chopper_pkg::mcc_chopconf_t'(pwdata & `MCC_CHOPCONF_WMASK);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_r   <= mcc_chopper_pkg::mcc_chopconf_t'(`MCC_CHOPCONF_RESET);
      rdata_r <= 32'h00000000;
      err_r   <= 1'b0;
    end
    else
    begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  assign pready  = psel && penable;
  assign prdata  = rdata_r;
  assign pslverr = psel && penable && err_r;

  // Pin and comparator inputs are asynchronous; two flops before any use
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic       stepPrev_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      syncA_r    <= 3'h0;
      syncB_r    <= 3'h0;
      stepPrev_r <= 1'b0;
    end
    else
    begin
      syncA_r    <= {currentTrip, dirIn, stepIn};
      syncB_r    <= syncA_r;
      stepPrev_r <= syncB_r[0];
    end
  end

  logic stepSync;
  logic dirSync;
  logic tripSync;
  logic stepEvent;

  assign stepSync = syncB_r[0];
  assign dirSync  = syncB_r[1];
  assign tripSync = syncB_r[2];
  assign stepEvent = cfg_r.doubleEdge ? (stepSync != stepPrev_r)
                                      : (stepSync && !stepPrev_r);

  // Microstep sequencing
  logic [9:0]  pos_r;
  logic [9:0]  pos_nxt;
  logic [8:0]  pend_r;
  logic [8:0]  pend_nxt;
  logic        fullStep_r;
  logic        fullStep_nxt;
  logic        pendDir_r;
  logic        pendDir_nxt;
  logic [3:0]  resEff;
  logic [9:0]  stepWidth;
  logic [9:0]  halfWidth;
  logic [9:0]  alignMask;
  logic        highVelFs;

  assign highVelFs = cfg_r.highVelFullStep && velocityHigh;
  // Codes above full step are unused; clamp so the width stays defined
  assign resEff    = fullStep_r ? `MCC_MICROSTEP_RESOLUTION_FULL_STEP
                   : ((cfg_r.microstepResolution > `MCC_MICROSTEP_RESOLUTION_FULL_STEP)
                      ? `MCC_MICROSTEP_RESOLUTION_FULL_STEP : cfg_r.microstepResolution);
  assign stepWidth = 10'(10'h001 << resEff);
  assign halfWidth = {1'b0, stepWidth[9:1]};
  assign alignMask = ~(stepWidth - 10'h001);

  always_comb
  begin
    pos_nxt      = pos_r;
    pend_nxt     = pend_r;
    pendDir_nxt  = pendDir_r;
    fullStep_nxt = fullStep_r;
    if (!highVelFs)
      fullStep_nxt = 1'b0;
    else if (pos_r[7:0] == `MCC_POS_45_DEG)
      fullStep_nxt = 1'b1;
    if (pend_r != 9'h000)
    begin
      pos_nxt  = pendDir_r ? pos_r - 10'h001 : pos_r + 10'h001;
      pend_nxt = pend_r - 9'h001;
    end
    else if (stepEvent)
    begin
      if (cfg_r.interpolate && resEff != 4'h0 && !fullStep_r)
      begin
        // Spread the coarse step into single microsteps, one per clock
        pendDir_nxt = dirSync;
        pend_nxt    = stepWidth[8:0];
        if (resEff == `MCC_MICROSTEP_RESOLUTION_FULL_STEP)
          pend_nxt = 9'h100;
      end
      else
      begin
        // Snap to the centre of each coarse cell: symmetric, hits 45 degrees
        pos_nxt = ((dirSync ? pos_r - stepWidth : pos_r + stepWidth) & alignMask)
                  | halfWidth;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pos_r      <= 10'h000;
      pend_r     <= 9'h000;
      pendDir_r  <= 1'b0;
      fullStep_r <= 1'b0;
    end
    else
    begin
      pos_r      <= pos_nxt;
      pend_r     <= pend_nxt;
      pendDir_r  <= pendDir_nxt;
      fullStep_r <= fullStep_nxt;
    end
  end

  assign microstepPos = pos_r;

  // Chopper timing
  logic          highVelChm;
  logic          driverOn;
  logic [TW-1:0] blankCount;
  logic [TW-1:0] offCount;
  logic [TW-1:0] pfdCount;

  assign highVelChm = cfg_r.highVelChopper && velocityHigh;
  assign driverOn   = (cfg_r.slowDecayOffTime != 4'h0);

  always_comb
  begin
    case (cfg_r.comparatorBlankTime)
      2'h0:    blankCount = `MCC_BLANK_CODE0;
      2'h1:    blankCount = `MCC_BLANK_CODE1;
      2'h2:    blankCount = `MCC_BLANK_CODE2;
      default: blankCount = `MCC_BLANK_CODE3;
    endcase
  end

  // The doubled count tops out at 1008 clocks, inside the timer width
  assign offCount = highVelChm
                  ? TW'((`MCC_OFF_BASE_CLOCKS + `MCC_OFF_CLOCKS_PER_UNIT
                         * TW'(cfg_r.slowDecayOffTime)) << 1)
                  : TW'(`MCC_OFF_BASE_CLOCKS + `MCC_OFF_CLOCKS_PER_UNIT
                        * TW'(cfg_r.slowDecayOffTime));
  assign pfdCount = TW'(`MCC_PFD_CLOCKS_PER_UNIT * TW'(cfg_r.passiveFastDecayTime));

  mcc_chopper_pkg::mcc_phase_t phase_r;
  mcc_chopper_pkg::mcc_phase_t phase_nxt;
  logic                        blankLoad;
  logic                        offLoad;
  logic                        pfdLoad;
  logic                        blankBusy;
  logic                        offBusy;
  logic                        pfdBusy;

  always_comb
  begin
    phase_nxt = phase_r;
    blankLoad = 1'b0;
    offLoad   = 1'b0;
    pfdLoad   = 1'b0;
    if (!driverOn)
      phase_nxt = mcc_chopper_pkg::MCC_IDLE;
    else if (polarityChange && cfg_r.passiveFastDecayTime != 4'h0)
    begin
      phase_nxt = mcc_chopper_pkg::MCC_PFD;
      pfdLoad   = 1'b1;
    end
    else
    begin
      case (phase_r)
        mcc_chopper_pkg::MCC_IDLE:
        begin
          phase_nxt = mcc_chopper_pkg::MCC_ON;
          blankLoad = 1'b1;
        end
        mcc_chopper_pkg::MCC_PFD:
          if (!pfdBusy)
          begin
            phase_nxt = mcc_chopper_pkg::MCC_ON;
            blankLoad = 1'b1;
          end
        mcc_chopper_pkg::MCC_ON:
          if (polarityChange)
            blankLoad = 1'b1;
          else if (!blankBusy && tripSync)
          begin
            phase_nxt = mcc_chopper_pkg::MCC_SLOW;
            offLoad   = 1'b1;
          end
        mcc_chopper_pkg::MCC_SLOW:
          if (!offBusy)
          begin
            phase_nxt = mcc_chopper_pkg::MCC_ON;
            blankLoad = 1'b1;
          end
        default:
          phase_nxt = mcc_chopper_pkg::MCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      phase_r <= mcc_chopper_pkg::MCC_IDLE;
    else
      phase_r <= phase_nxt;
  end

  mcc_phase_timer #(.WIDTH(TW)) blankTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (blankLoad),
    .count   (blankCount),
    .busy    (blankBusy)
  );

  mcc_phase_timer #(.WIDTH(TW)) offTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (offLoad),
    .count   (offCount - TW'(1)),  // Exit test costs one edge, so load one short
    .busy    (offBusy)
  );

  mcc_phase_timer #(.WIDTH(TW)) pfdTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (pfdLoad),
    .count   (pfdCount - TW'(1)),  // Only loaded with a nonzero setting
    .busy    (pfdBusy)
  );

  // Drive control outputs come from the register and flops, with velocityHigh gating chopperModeEff and fastDecaySelectEff
  assign driveCtl.supplyShortProtectOn = !cfg_r.supplyShortProtectOff;
  assign driveCtl.groundShortProtectOn = !cfg_r.groundShortProtectOff;
  assign driveCtl.driverEnable         = driverOn;
  assign driveCtl.chopperModeEff       = cfg_r.chopperMode || highVelChm;
  assign driveCtl.fastDecaySelectEff   = highVelChm ? 1'b0 : cfg_r.fastDecaySelect;
  assign driveCtl.fullStepActive       = fullStep_r;

  assign bridgeState.bridgesOff       = (phase_r == mcc_chopper_pkg::MCC_IDLE);
  assign bridgeState.blanking         = (phase_r == mcc_chopper_pkg::MCC_ON) && blankBusy;
  assign bridgeState.onPhase          = (phase_r == mcc_chopper_pkg::MCC_ON);
  assign bridgeState.slowDecay        = (phase_r == mcc_chopper_pkg::MCC_SLOW);
  assign bridgeState.passiveFastDecay = (phase_r == mcc_chopper_pkg::MCC_PFD);

endmodule
`default_nettype wire

// [test/mcc_motor_chopper_config_assertions.sv]
`default_nettype none
module mcc_motor_chopper_config_assertions (
  input wire logic                               ref_clk,
  input wire logic                               rst,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [11:0]                        paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic [31:0]                        prdata,
  input wire logic                               pslverr,
  input wire logic                               polarityChange,
  input wire logic                               velocityHigh,
  input wire mcc_chopper_pkg::mcc_drive_ctl_t    driveCtl,
  input wire mcc_chopper_pkg::mcc_bridge_state_t bridgeState,
  input wire logic [9:0]                         microstepPos
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLK [4] = '{16, 24, 36, 54};
  logic [31:0] shadowR;
  logic [10:0] pfdCnt, slowCnt, blankCnt, slowExp;
  logic [7:0]  posQ;
  logic [1:0]  tblQ;
  logic        axs, wrHit;
  assign axs = psel && penable;
  assign wrHit = axs && pwrite && paddr == 12'h1b4;
  // Slow and blank lengths are latched when a phase starts, so a rewrite mid-phase cannot skew them
  always_ff @(posedge ref_clk)
  begin
    shadowR <= rst ? 32'h10410150 : wrHit ? pwdata & 32'hfffddfff : shadowR;
    pfdCnt <= bridgeState.passiveFastDecay && !polarityChange ? pfdCnt + 11'h1 : 11'h0;
    slowCnt <= bridgeState.slowDecay ? slowCnt + 11'h1 : 11'h0;
    // A polarity change in the on phase restarts blanking, so the count restarts too
    blankCnt <= bridgeState.blanking && !polarityChange ? blankCnt + 11'h1 : 11'h0;
    slowExp <= bridgeState.slowDecay ? slowExp
             : (11'd24 + 11'd32 * shadowR[3:0]) << (shadowR[19] && velocityHigh);
    tblQ <= bridgeState.blanking ? tblQ : shadowR[16:15];
    posQ <= microstepPos[7:0];
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_supply_prot: assert property (driveCtl.supplyShortProtectOn == !shadowR[31])
    else $error("supply protection wrong");
  a_ground_prot: assert property (driveCtl.groundShortProtectOn == !shadowR[30])
    else $error("ground protection wrong");
  a_drv_enable: assert property (driveCtl.driverEnable == (shadowR[3:0] != 4'h0))
    else $error("driver enable wrong");
  a_bridges_off: assert property (shadowR[3:0] == 4'h0 |=> bridgeState.bridgesOff)
    else $error("bridges not off");
  a_high_chm: assert property (shadowR[19] && velocityHigh |-> driveCtl.chopperModeEff)
    else $error("chopper mode not forced");
  a_high_fd: assert property (driveCtl.fastDecaySelectEff ==
    (shadowR[11] && !(shadowR[19] && velocityHigh))) else $error("fast decay select wrong");
  a_reg_read: assert property (axs && paddr == 12'h1b4 |->
    !pslverr && (pwrite || prdata == shadowR)) else $error("register read wrong");
  a_unmapped: assert property (axs && paddr != 12'h1b4 |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access wrong");
  a_pfd_len: assert property ($fell(bridgeState.passiveFastDecay) && !$past(rst)
    && shadowR[3:0] != 4'h0 |-> pfdCnt == 11'd128 * shadowR[23:20])
    else $error("passive fast decay length wrong");
  a_slow_len: assert property ($fell(bridgeState.slowDecay) && !$past(rst)
    && !$past(polarityChange) && shadowR[3:0] != 4'h0 |-> slowCnt == slowExp)
    else $error("slow decay length wrong");
  a_blank_len: assert property ($fell(bridgeState.blanking) && !$past(rst)
    && !$past(polarityChange) && shadowR[3:0] != 4'h0 |-> blankCnt == BLK[tblQ])
    else $error("blank length wrong");
  a_full_step: assert property ($rose(driveCtl.fullStepActive) && !$past(rst)
    |-> posQ == 8'h80) else $error("full step off the 45 degree point");
endmodule
bind mcc_motor_chopper_config mcc_motor_chopper_config_assertions u_chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .polarityChange(polarityChange), .velocityHigh(velocityHigh), .driveCtl(driveCtl),
  .bridgeState(bridgeState), .microstepPos(microstepPos));
`default_nettype wire

// [test/mcc_bridge_model.sv]
`default_nettype none
module mcc_bridge_model (
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  input  wire mcc_chopper_pkg::mcc_bridge_state_t bridgeState,
  input  wire logic [7:0]                         riseTime,
  input  wire logic                               polReq,
  output logic                                    currentTrip,
  output logic                                    polarityChange
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] onCnt;
  logic       polQ;
  // Current climbs only while driven; a short riseTime trips inside blanking
  always_ff @(posedge ref_clk)
  begin
    onCnt <= rst || !bridgeState.onPhase ? 8'h00 : onCnt + {7'h00, onCnt != 8'hff};
    currentTrip <= !rst && bridgeState.onPhase && onCnt >= riseTime;
    polQ <= polReq;
    polarityChange <= !rst && polReq && !polQ;
  end
endmodule
`default_nettype wire

// [test/test_motor_chopper_config.sv]
`default_nettype none
module test_motor_chopper_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, errQ;
  logic        stepIn, dirIn, currentTrip, polarityChange, velocityHigh, polReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [9:0]  microstepPos, expPos;
  logic [7:0]  riseTime;
  int          mismatches, checked, cycles, microstep_resolution;
  int          blk [4] = '{16, 24, 36, 54};
  mcc_chopper_pkg::mcc_drive_ctl_t    driveCtl;
  mcc_chopper_pkg::mcc_bridge_state_t bridgeState;
  mcc_motor_chopper_config dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stepIn(stepIn), .dirIn(dirIn), .currentTrip(currentTrip),
    .polarityChange(polarityChange), .velocityHigh(velocityHigh), .driveCtl(driveCtl),
    .bridgeState(bridgeState), .microstepPos(microstepPos));
  mcc_bridge_model coil (
    .ref_clk(ref_clk), .rst(rst), .bridgeState(bridgeState), .riseTime(riseTime),
    .polReq(polReq), .currentTrip(currentTrip), .polarityChange(polarityChange));
  always #4 ref_clk = ~ref_clk;
  task automatic summarize();
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdv = prdata;
    errQ = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [31:0] d);
    apb(1'b1, 12'h1b4, d);
  endtask
  task automatic rd(input logic [31:0] x);
    apb(1'b0, 12'h1b4, 32'h0);
    chk("chopper_configuration", x, rdv);
  endtask
  function automatic logic [9:0] nxt(input logic [9:0] p, input logic d);
    logic [9:0] s;
    s = 10'(1 << microstep_resolution);
    return ((d ? p - s : p + s) & ~(s - 10'h001)) | (s >> 1);
  endfunction
  task automatic step(input logic d, input logic dbl);
    dirIn <= d;
    stepIn <= 1'b1;
    expPos = nxt(expPos, d);
    repeat (8) @(posedge ref_clk);
    chk("microstepPos", 32'(expPos), 32'(microstepPos));
    stepIn <= 1'b0;
    if (dbl)
      expPos = nxt(expPos, d);
    repeat (8) @(posedge ref_clk);
    chk("microstepPos", 32'(expPos), 32'(microstepPos));
  endtask
  task automatic waitb(input int b, input logic v);
    int n;
    n = 0;
    while (bridgeState[b] !== v && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic meas(input int b, input int x);
    int n;
    waitb(b, 1'b0);
    waitb(b, 1'b1);
    n = 0;
    while (bridgeState[b] === 1'b1 && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("phase cycles", 32'(x), 32'(n));
  endtask
  task automatic t_regs();
    rd(32'h10410150);
    chk("bridgesOff", 32'h1, 32'(bridgeState.bridgesOff));
    wr(32'hffffffff);
    rd(32'hfffddfff);
    chk("protection", 32'h0, 32'(driveCtl[5:4]));
    wr(32'h40000000);
    chk("protection", 32'h2, 32'(driveCtl[5:4]));
    apb(1'b1, 12'h1b8, 32'hffffffff);
    chk("pslverr", 32'h1, 32'(errQ));
    apb(1'b0, 12'h1b8, 32'h0);
    chk("unmapped read", 32'h00000000, rdv);
    rd(32'h40000000);
  endtask
  task automatic t_step();
    logic [9:0] nx;
    expPos = 10'h000;
    for (int m = 0; m < 9; m++)
    begin
      microstep_resolution = m;
      wr(32'(m) << 24);
      step(1'b0, 1'b0);
    end
    step(1'b1, 1'b0);
    wr(32'h28000000);
    step(1'b1, 1'b1);
    velocityHigh <= 1'b1;
    wr(32'h080c0000);
    step(1'b0, 1'b0);
    chk("fullStepActive", 32'h1, 32'(driveCtl.fullStepActive));
    chk("chopperModeEff", 32'h1, 32'(driveCtl.chopperModeEff));
    velocityHigh <= 1'b0;
    wr(32'h18000000);
    stepIn <= 1'b1;
    nx = nxt(expPos, 1'b0);
    repeat (40) @(posedge ref_clk);
    chk("draining", 32'h1, 32'(microstepPos !== expPos && microstepPos !== nx));
    repeat (300) @(posedge ref_clk);
    expPos = nx;
    chk("microstepPos", 32'(expPos), 32'(microstepPos));
    stepIn <= 1'b0;
  endtask
  task automatic t_chop();
    for (int t = 0; t < 4; t++)
    begin
      wr((32'(t) << 15) | 32'h1);
      meas(3, blk[t]);
    end
    chk("driverEnable", 32'h1, 32'(driveCtl.driverEnable));
    riseTime <= 8'd90;
    meas(1, 56);
    riseTime <= 8'd4;
    velocityHigh <= 1'b1;
    wr(32'h00088801);
    meas(1, 112);
    chk("fastDecaySelectEff", 32'h0, 32'(driveCtl.fastDecaySelectEff));
    velocityHigh <= 1'b0;
    @(posedge ref_clk);
    chk("fastDecaySelectEff", 32'h1, 32'(driveCtl.fastDecaySelectEff));
    for (int p = 1; p >= 0; p--)
    begin
      wr((32'(p) << 20) | 32'h00008001);
      polReq <= 1'b1;
      @(posedge ref_clk);
      polReq <= 1'b0;
      meas(0, 128 * p);
    end
    wr(32'h0);
    repeat (3) @(posedge ref_clk);
    chk("bridgesOff", 32'h1, 32'(bridgeState.bridgesOff));
  endtask
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stepIn = 1'b0;
    dirIn = 1'b0;
    velocityHigh = 1'b0;
    polReq = 1'b0;
    riseTime = 8'd4;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_step();
    t_chop();
    summarize();
  end
endmodule
`default_nettype wire
